// ### design/wdrst_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdrst_params.svh"

module wdrst_counter
   import wdrst_pkg::*;
#(
   parameter int BASE_LOG2 = `WDRST_BASE_LOG2
) (
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   input  wire logic              clear_i,
   input  wire logic              run_i,
   input  wire logic              tick_i,
   input  wire wdrst_pkg::wdrst_sel_t sel_i,
   output logic                   expire_o
);

   localparam int CNT_W = BASE_LOG2 + 7;
   localparam logic [CNT_W-1:0] ONE = {{(CNT_W-1){1'b0}}, 1'b1};

   logic [CNT_W-1:0] cnt_q;
   logic             expire_q;
   logic             at_end;

   function automatic logic [CNT_W-1:0] wd_last(input wdrst_sel_t sel);
      wd_last = (ONE << (BASE_LOG2 + int'(sel))) - ONE;
   endfunction

   // >= so a shortened period takes effect at once
   assign at_end = (cnt_q >= wd_last(sel_i));

   always_ff @(posedge clk_i) begin
      if (!rst_n_i || clear_i || !run_i) begin
         cnt_q    <= '0;
         expire_q <= 1'b0;
      end else if (tick_i) begin
         cnt_q    <= at_end ? '0 : cnt_q + ONE;
         expire_q <= at_end;
      end else begin
         expire_q <= 1'b0;
      end
   end

   assign expire_o = expire_q;

endmodule

`default_nettype wire

// ### design/wdrst_sync.sv
`timescale 1ns/1ps
`default_nettype none

module wdrst_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // first stage feeds only the second stage
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;

endmodule

`default_nettype wire

// ### design/wdrst_top.sv
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "wdrst_params.svh"

module wdrst_top #(
   parameter int BASE_LOG2 = `WDRST_BASE_LOG2,
   parameter int OSC_DIV   = `WDRST_OSC_DIV
) (
   input  wire logic                      clk_i,
   input  wire logic                      rst_n_i,
   input  wire logic                      psel_i,
   input  wire logic                      penable_i,
   input  wire logic                      pwrite_i,
   input  wire logic [`WDRST_ADDR_W-1:0]  paddr_i,
   input  wire logic [31:0]               pwdata_i,
   input  wire logic [3:0]                pstrb_i,
   output logic      [31:0]               prdata_o,
   output logic                           pready_o,
   output logic                           pslverr_o,
   input  wire logic                      always_on_fuse_i,
   input  wire logic                      pin_reset_i,
   input  wire logic                      supply_drop_i,
   input  wire logic                      scan_reset_i,
   input  wire logic                      restart_i,
   output logic                           dog_reset_o,
   output logic                           watchdog_running_o,
   output wdrst_pkg::wdrst_level_t        safety_level_o
);
   import wdrst_pkg::*;

   localparam int DIV_W = $clog2(OSC_DIV);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_DIV - 1);
   localparam logic [2:0] WIN_LOAD = 3'(`WDRST_UNLOCK_CYCLES);
   localparam logic [1:0] SETTLE   = 2'(`WDRST_FUSE_SETTLE);

   // synchronised pins
   logic [3:0] pins_s;
   logic       fuse_s;
   logic       pin_s;
   logic       drop_s;
   logic       scan_s;

   wdrst_sync #(
      .WIDTH (4)
   ) u_sync (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .async_i ({always_on_fuse_i, pin_reset_i, supply_drop_i, scan_reset_i}),
      .sync_o  (pins_s)
   );

   assign fuse_s = pins_s[3];
   assign pin_s  = pins_s[2];
   assign drop_s = pins_s[1];
   assign scan_s = pins_s[0];

   // state
   logic [1:0]       settle_q;
   wdrst_level_t     level_q;
   logic             on_q;
   wdrst_sel_t       sel_q;
   logic             unlock_q;
   logic [2:0]       win_q;
   logic [4:0]       stat_q;
   logic [DIV_W-1:0] div_q;
   logic             tick_q;
   logic [31:0]      rdata_q;
   logic             err_q;

   // apb decode
   logic       setup;
   logic       wr_acc;
   logic       hit_ctrl;
   logic       hit_stat;
   logic       mapped;
   logic       wr_ctrl;
   logic       wr_stat;
   logic [7:0] wbyte;
   logic       w_unlock;
   logic       w_on;
   wdrst_sel_t w_sel;

   assign setup    = psel_i & ~penable_i;
   assign wr_acc   = psel_i & penable_i & pwrite_i;
   assign hit_ctrl = (paddr_i[`WDRST_ADDR_W-1:2] == (`WDRST_ADDR_W-2)'(`WDRST_CTRL_OFFSET >> 2));
   assign hit_stat = (paddr_i[`WDRST_ADDR_W-1:2] == (`WDRST_ADDR_W-2)'(`WDRST_STAT_OFFSET >> 2));
   assign mapped   = hit_ctrl | hit_stat;
   // only byte lane 0 holds bits; other lanes are ignored
   assign wr_ctrl  = wr_acc & hit_ctrl & pstrb_i[0];
   assign wr_stat  = wr_acc & hit_stat & pstrb_i[0];
   assign wbyte    = pwdata_i[7:0];
   assign w_unlock = wbyte[`WDRST_CTRL_UNLOCK_BIT];
   assign w_on     = wbyte[`WDRST_CTRL_ON_BIT];
   assign w_sel    = wbyte[`WDRST_CTRL_SEL_MSB:`WDRST_CTRL_SEL_LSB];

   // write classes
   logic unlock_wr;
   logic prot_wr;
   logic plain_wr;
   logic lvl2;

   assign lvl2      = (level_q == WDRST_LEVEL2);
   assign unlock_wr = wr_ctrl & w_unlock & w_on;
   // protected only while the window is still open
   assign prot_wr   = wr_ctrl & ~w_unlock & unlock_q;
   assign plain_wr  = wr_ctrl & ~unlock_wr & ~prot_wr;

   // chip reset sources other than power-on
   logic dog_expire;
   logic chip_rst;

   assign chip_rst = pin_s | drop_s | scan_s | dog_reset_o;

   // fuse is sampled for a few cycles after release, then frozen
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         settle_q <= '0;
         level_q  <= WDRST_LEVEL1;
      end else if (settle_q != SETTLE) begin
         settle_q <= settle_q + 2'h1;
         level_q  <= wdrst_level_t'(fuse_s);
      end
   end

   // watchdog_control
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || chip_rst) begin
         on_q     <= 1'b0;
         sel_q    <= '0;
         unlock_q <= 1'b0;
         win_q    <= '0;
      end else begin
         if (unlock_wr) begin
            on_q     <= 1'b1;
            unlock_q <= 1'b1;
            win_q    <= WIN_LOAD;
         end else if (prot_wr) begin
            // one change per unlock: window shuts after use
            unlock_q <= 1'b0;
            win_q    <= '0;
            sel_q    <= w_sel;
            if (!lvl2) begin
               on_q <= w_on;
            end
         end else begin
            if (plain_wr && w_on) begin
               on_q <= 1'b1;
            end
            if (win_q != 3'h0) begin
               win_q <= win_q - 3'h1;
            end
            if (win_q == 3'h1) begin
               unlock_q <= 1'b0;
            end
         end
      end
   end

   // level 2 forces the dog on regardless of on_q
   logic run;
   assign run = on_q | lvl2;

   // oscillator tick as clock enable
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         div_q  <= '0;
         tick_q <= 1'b0;
      end else begin
         tick_q <= (div_q == DIV_LAST);
         div_q  <= (div_q == DIV_LAST) ? '0 : div_q + DIV_W'(1);
      end
   end

   wdrst_counter #(
      .BASE_LOG2 (BASE_LOG2)
   ) u_counter (
      .clk_i    (clk_i),
      .rst_n_i  (rst_n_i),
      .clear_i  (restart_i | chip_rst),
      .run_i    (run),
      .tick_i   (tick_q),
      .sel_i    (sel_q),
      .expire_o (dog_expire)
   );

   assign dog_reset_o = dog_expire;

   // reset_cause_status: set beats a write of zero
   logic [4:0] stat_set;
   logic [4:0] stat_keep;

   assign stat_set  = {scan_s, dog_reset_o, drop_s, pin_s, 1'b0};
   assign stat_keep = wr_stat ? (stat_q & wbyte[4:0]) : stat_q;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         stat_q <= `WDRST_STAT_POR_VALUE;
      end else begin
         stat_q <= stat_keep | stat_set;
      end
   end

   // read data captured in setup, held through access
   logic [7:0] ctrl_rd;
   logic [7:0] rd_mux;

   assign ctrl_rd = {3'b000, unlock_q, run, sel_q};
   assign rd_mux  = hit_ctrl ? ctrl_rd : (hit_stat ? {3'b000, stat_q} : 8'h00);

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rdata_q <= '0;
         err_q   <= 1'b0;
      end else if (setup) begin
         rdata_q <= {24'h000000, rd_mux};
         err_q   <= ~mapped;
      end
   end

   assign pready_o           = psel_i & penable_i;
   assign pslverr_o          = psel_i & penable_i & err_q;
   assign prdata_o           = rdata_q;
   assign watchdog_running_o = run;
   assign safety_level_o     = level_q;

endmodule

`default_nettype wire

// ### include/wdrst_params.svh
`ifndef WDRST_PARAMS_SVH
`define WDRST_PARAMS_SVH

// register map, byte addresses on the apb slave
`define WDRST_ADDR_W          12
`define WDRST_CTRL_OFFSET     12'h060
`define WDRST_STAT_OFFSET     12'h064

// watchdog_control fields
`define WDRST_CTRL_UNLOCK_BIT 4
`define WDRST_CTRL_ON_BIT     3
`define WDRST_CTRL_SEL_MSB    2
`define WDRST_CTRL_SEL_LSB    0
`define WDRST_CTRL_RESET      8'h00

// reset_cause_status fields
`define WDRST_STAT_SCAN_BIT   4
`define WDRST_STAT_DOG_BIT    3
`define WDRST_STAT_DROP_BIT   2
`define WDRST_STAT_PIN_BIT    1
`define WDRST_STAT_PWR_BIT    0
`define WDRST_STAT_POR_VALUE  5'h01

// timing
`define WDRST_CLK_HZ          40000000
`define WDRST_OSC_HZ          1000000
`define WDRST_OSC_DIV         (`WDRST_CLK_HZ / `WDRST_OSC_HZ)
`define WDRST_UNLOCK_CYCLES   4
`define WDRST_BASE_LOG2       14
`define WDRST_FUSE_SETTLE     3

`endif

// ### include/wdrst_pkg.sv
package wdrst_pkg;

   typedef enum logic {
      WDRST_LEVEL1 = 1'b0,
      WDRST_LEVEL2 = 1'b1
   } wdrst_level_t;

   typedef logic [2:0] wdrst_sel_t;

endpackage

// ### test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdrst_params.svh"
module tb_top;
   import wdrst_pkg::*;
   localparam logic [11:0] CA = `WDRST_CTRL_OFFSET;
   localparam logic [11:0] SA = `WDRST_STAT_OFFSET;
   logic         clk_i, rst_n_i = 0, psel = 0, pen = 0, pwr = 0, fuse = 0, restart = 1;
   logic [11:0]  paddr = 0;
   logic [31:0]  pwdata = 0, prdata;
   logic [2:0]   src = 0;
   logic [7:0]   r, d;
   logic         rdy, err, dog, run, e;
   wdrst_level_t lvl;
   int           failures = 0, comparisons = 0, n;
   wdrst_top #(.BASE_LOG2(2), .OSC_DIV(4)) u_wdrst_top (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
      .pstrb_i(4'hf), .prdata_o(prdata), .pready_o(rdy), .pslverr_o(err),
      .always_on_fuse_i(fuse), .pin_reset_i(src[0]), .supply_drop_i(src[1]),
      .scan_reset_i(src[2]), .restart_i(restart), .dog_reset_o(dog),
      .watchdog_running_o(run), .safety_level_o(lvl));
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   function automatic logic [7:0] ctrl_exp(logic on, logic [2:0] sel);
      return {4'h0, on, sel};
   endfunction
   function automatic int period(int sel);
      return (1 << (2 + sel)) * 4;
   endfunction
   function automatic logic [7:0] smask(int k);
      return (k == 2) ? 8'h10 : 8'h02 << k;
   endfunction
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      comparisons++;
      if (s !== x) begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, s, x);
      end
   endtask
   // upper data bits random: the block must ignore them
   task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] v);
      @(posedge clk_i);
      psel   <= 1'b1;
      pwr    <= w;
      paddr  <= a;
      pwdata <= {24'($urandom()), v};
      @(posedge clk_i);
      pen <= 1'b1;
      do @(posedge clk_i); while (rdy !== 1'b1);
      r = prdata[7:0];
      e = err;
      psel <= 1'b0;
      pen  <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] x);
      xfer(1'b0, a, 8'h00);
      chk(32'(r), 32'(x));
   endtask
   task automatic end_sim;
      $display("counts: %0d comparisons, %0d failures", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #(25 * 40000);
      failures++;
      end_sim();
   end
   initial begin
      void'($urandom(10));
      repeat (10) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rd(CA, 8'h00);
      rd(SA, 8'h01);
      rd(12'h068, 8'h00);
      chk(32'(e), 32'h1);
      $display("done: reset values");
      for (int k = 0; k < 3; k++) begin
         src <= 3'h1 << k;
         repeat (2 + $urandom_range(3)) @(posedge clk_i);
         src <= 3'h0;
         repeat (4) @(posedge clk_i);
         rd(SA, 8'h01 | smask(k));
         xfer(1'b1, SA, 8'h01);
         rd(SA, 8'h01);
      end
      xfer(1'b1, SA, 8'h00);
      rd(SA, 8'h00);
      $display("done: reset causes");
      xfer(1'b1, CA, 8'h08);
      // running flag updates on the access edge itself
      @(posedge clk_i);
      chk(32'(run), 32'h1);
      xfer(1'b1, CA, 8'h05);
      rd(CA, 8'h08);
      xfer(1'b1, CA, 8'h18);
      rd(CA, 8'h18);
      repeat (2) @(posedge clk_i);
      rd(CA, 8'h08);
      xfer(1'b1, CA, 8'h03);
      rd(CA, 8'h08);
      xfer(1'b1, CA, 8'h18);
      d = ctrl_exp(1'($urandom_range(1)), 3'($urandom_range(7)));
      xfer(1'b1, CA, d);
      rd(CA, d);
      chk(32'(run), 32'(d[3]));
      $display("done: unlock window");
      // stop the dog while restart still holds the counter clear
      xfer(1'b1, CA, 8'h18);
      xfer(1'b1, CA, 8'h00);
      restart <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         xfer(1'b1, CA, 8'h18);
         n = 3;
         xfer(1'b1, CA, ctrl_exp(1'b1, 3'(i)));
         while (dog !== 1'b1) begin
            @(posedge clk_i);
            n++;
         end
         chk(32'(n >= period(i) - 6 && n <= period(i) + 6), 32'h1);
         rd(SA, 8'h08);
         xfer(1'b1, SA, 8'h00);
      end
      restart <= 1'b1;
      $display("done: expiry periods");
      fuse    <= 1'b1;
      rst_n_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      chk(32'(lvl), 32'(WDRST_LEVEL2));
      rd(SA, 8'h01);
      rd(CA, 8'h08);
      xfer(1'b1, CA, 8'h18);
      xfer(1'b1, CA, ctrl_exp(1'b0, 3'h6));
      rd(CA, 8'h0e);
      chk(32'(run), 32'h1);
      $display("done: level 2");
      end_sim();
   end
endmodule
`default_nettype wire

// ### test/wdrst_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdrst_params.svh"
module wdrst_sva
   import wdrst_pkg::*;
#(
   parameter int BASE_LOG2 = 2,
   parameter int OSC_DIV   = 4
) (
   input wire logic                     clk_i,
   input wire logic                     rst_n_i,
   input wire logic                     psel_i,
   input wire logic                     penable_i,
   input wire logic                     pwrite_i,
   input wire logic [`WDRST_ADDR_W-1:0] paddr_i,
   input wire logic [31:0]              prdata_o,
   input wire logic                     restart_i,
   input wire logic                     dog_reset_o,
   input wire logic                     watchdog_running_o,
   input wire wdrst_pkg::wdrst_level_t  safety_level_o
);
   logic     [2:0] gap_q;
   wire logic      ctrl_acc = psel_i & penable_i & (paddr_i == `WDRST_CTRL_OFFSET);
   // cycles since last control write, saturating
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) gap_q <= 3'h7;
      else if (ctrl_acc && pwrite_i) gap_q <= 3'h0;
      else if (gap_q != 3'h7) gap_q <= gap_q + 3'h1;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   property p_dog_pulse;
      dog_reset_o |=> !dog_reset_o;
   endproperty
   a_dog_pulse: assert property (p_dog_pulse)
      else $error("dog reset longer than one cycle");
   property p_lvl2_run;
      safety_level_o == WDRST_LEVEL2 |-> watchdog_running_o;
   endproperty
   a_lvl2_run: assert property (p_lvl2_run)
      else $error("level 2 not running");
   property p_lvl2_stay;
      safety_level_o == WDRST_LEVEL2 |=> safety_level_o == WDRST_LEVEL2 && watchdog_running_o;
   endproperty
   a_lvl2_stay: assert property (p_lvl2_stay)
      else $error("level 2 watchdog stopped");
   property p_lvl1_start;
      $rose(rst_n_i) |-> !watchdog_running_o && safety_level_o == WDRST_LEVEL1;
   endproperty
   a_lvl1_start: assert property (p_lvl1_start)
      else $error("watchdog running out of reset");
   property p_rsvd;
      ctrl_acc && !pwrite_i |-> prdata_o[7:5] == 3'h0;
   endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("reserved control bits nonzero");
   // read data is captured in setup, so five idle cycles are needed
   property p_unlock_close;
      ctrl_acc && !pwrite_i && gap_q >= 3'h5 |-> !prdata_o[4];
   endproperty
   a_unlock_close: assert property (p_unlock_close)
      else $error("unlock bit still set");
   property p_restart;
      restart_i |-> ##3 !dog_reset_o [*5];
   endproperty
   a_restart: assert property (p_restart)
      else $error("expiry right after restart");
   property p_dog_stop;
      dog_reset_o && safety_level_o == WDRST_LEVEL1 |=> !watchdog_running_o;
   endproperty
   a_dog_stop: assert property (p_dog_stop)
      else $error("level 1 still running after dog reset");
endmodule
bind wdrst_top wdrst_sva #(.BASE_LOG2(BASE_LOG2), .OSC_DIV(OSC_DIV)) u_wdrst_sva (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .restart_i(restart_i),
   .dog_reset_o(dog_reset_o), .watchdog_running_o(watchdog_running_o),
   .safety_level_o(safety_level_o));
`default_nettype wire
